/* File: common/sas_map.svh */
// Purpose: offsets, fields, resets and counts of the converter sequencer
// Assumes: byte addresses on a 32-bit Avalon-MM slave, one word per register
// Notes: included by the design file and the testbench
`ifndef SAS_MAP_SVH
`define SAS_MAP_SVH
// register byte offsets
`define SAS_OFS_CTRL 5'h00
`define SAS_OFS_RESULT 5'h04
`define SAS_OFS_DIV 5'h08
`define SAS_OFS_STAT 5'h0c
`define SAS_OFS_MASK 5'h10
// control register fields
`define SAS_CTRL_SEL_LSB 0
`define SAS_CTRL_TRIG_LSB 4
`define SAS_CTRL_START_BIT 8
`define SAS_CTRL_DONE_BIT 12
// status and mask bits
`define SAS_ST_DONE 0
`define SAS_ST_LOST 1
// reset values
`define SAS_RST_SEL 4'h0
`define SAS_RST_DIV 5'h00
`define SAS_RST_MASK 2'h0
`define SAS_MAX_CH 4'ha
// conversion timing in converter clocks
`define SAS_CONV_CLKS 6'h3a
`define SAS_SAR_BITS 12
`define SAS_SAMPLE_CLKS 6'h2e
`define SAS_SAR_MSB 12'h800
`endif

/* File: common/sas_pkg.sv */
// Purpose: types shared by the converter sequencer
// Assumes: nothing beyond the map header
// Notes: states and trigger source encodings
package sas_pkg;
  typedef enum logic [1:0] {SAS_IDLE, SAS_SAMPLE, SAS_APPROX} sas_state_e;
  typedef enum logic [1:0]
  {
    SAS_TRIG_NONE,
    SAS_TRIG_TIMER,
    SAS_TRIG_PWM,
    SAS_TRIG_RSVD
  } sas_trig_e;
  typedef logic [11:0] sas_code_t;
endpackage

/* File: design/sas_adc_seq.sv */
// Purpose: sequencer for a 12-bit successive approximation converter
// Assumes: timer and comparator inputs synchronous to i_clk
// Notes: Avalon-MM slave answers one cycle after a request
//
// Local design decisions: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sas_map.svh"
module sas_adc_seq
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [2:0] i_timer_match,
  input wire logic i_pwm_trig,
  input wire logic i_cmp,
  output logic [3:0] o_mux_sel,
  output logic o_sample,
  output sas_pkg::sas_code_t o_dac_code,
  output logic o_busy,
  output logic o_irq
);
  import sas_pkg::*;

  sas_state_e state;
  logic [3:0] sel_field;
  sas_trig_e trig_sel;
  logic soft_start;
  logic done_flag;
  sas_code_t result;
  logic [4:0] div;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic [4:0] pre_cnt;
  logic tick;
  logic [5:0] conv_cnt;
  logic [3:0] bitpos;
  logic req;
  logic acc;
  logic hw_trig;
  logic any_trig;
  logic accept;
  logic finish;
  logic [1:0] lost_set;
  logic [1:0] done_set;
  logic wr_ctrl;
  logic [31:0] next_rdata;

  // bus handshake decode
  assign req = i_avs_read | i_avs_write;
  assign acc = req & ~o_avs_waitrequest;
  assign wr_ctrl = acc & i_avs_write & (i_avs_address == `SAS_OFS_CTRL);

  // trigger sources and acceptance
  always_comb
  begin
    unique case (trig_sel)
      SAS_TRIG_TIMER: hw_trig = |i_timer_match;
      SAS_TRIG_PWM: hw_trig = i_pwm_trig;
      default: hw_trig = 1'b0;
    endcase
  end
  assign any_trig = soft_start | hw_trig;
  // only an idle converter accepts, so a running one is never disturbed
  assign accept = (state == SAS_IDLE) & any_trig;
  assign finish = (state == SAS_APPROX) & tick & (bitpos == 4'h0);
  assign lost_set = {(state != SAS_IDLE) & hw_trig, 1'b0};
  assign done_set = {1'b0, finish};

  // single wait cycle then answer; read data ready with waitrequest low
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0;
    end
    else
    begin
      o_avs_waitrequest <= ~(req & o_avs_waitrequest);
      if (req & o_avs_waitrequest)
        o_avs_readdata <= next_rdata;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb
  begin
    next_rdata = 32'h0;
    unique case (i_avs_address)
      `SAS_OFS_CTRL:
      begin
        next_rdata[`SAS_CTRL_SEL_LSB +: 4] = sel_field;
        next_rdata[`SAS_CTRL_TRIG_LSB +: 2] = trig_sel;
        next_rdata[`SAS_CTRL_START_BIT] = soft_start;
        next_rdata[`SAS_CTRL_DONE_BIT] = done_flag;
      end
      `SAS_OFS_RESULT: next_rdata[11:0] = result;
      `SAS_OFS_DIV: next_rdata[4:0] = div;
      `SAS_OFS_STAT: next_rdata[1:0] = irq_stat;
      `SAS_OFS_MASK: next_rdata[1:0] = irq_mask;
      default: next_rdata = 32'h0;
    endcase
  end

  // software-written configuration
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sel_field <= `SAS_RST_SEL;
      trig_sel <= SAS_TRIG_NONE;
      div <= `SAS_RST_DIV;
      irq_mask <= `SAS_RST_MASK;
    end
    else if (acc & i_avs_write)
    begin
      if (i_avs_address == `SAS_OFS_CTRL)
      begin
        sel_field <= i_avs_writedata[`SAS_CTRL_SEL_LSB +: 4];
        trig_sel <= sas_trig_e'(i_avs_writedata[`SAS_CTRL_TRIG_LSB +: 2]);
      end
      if (i_avs_address == `SAS_OFS_DIV)
        div <= i_avs_writedata[4:0];
      if (i_avs_address == `SAS_OFS_MASK)
        irq_mask <= i_avs_writedata[1:0];
    end
  end

  // soft start: write one sets while idle, acceptance clears
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      soft_start <= 1'b0;
    else if (accept)
      soft_start <= 1'b0;
    else if (wr_ctrl & i_avs_writedata[`SAS_CTRL_START_BIT])
      soft_start <= (state == SAS_IDLE);
  end

  // prescaler restarts on acceptance so every run has equal length
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pre_cnt <= 5'h0;
      tick <= 1'b0;
    end
    else if (accept || (pre_cnt >= div))
    begin
      pre_cnt <= 5'h0;
      tick <= ~accept;
    end
    else
    begin
      pre_cnt <= pre_cnt + 5'h1;
      tick <= 1'b0;
    end
  end

  // conversion sequence: sampling then one bit per converter clock
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state <= SAS_IDLE;
      conv_cnt <= 6'h0;
      bitpos <= 4'h0;
      o_dac_code <= 12'h0;
      o_mux_sel <= `SAS_RST_SEL;
    end
    else
    begin
      unique case (state)
        SAS_IDLE:
          if (accept)
          begin
            state <= SAS_SAMPLE;
            conv_cnt <= 6'h0;
            // out-of-range select falls back to input 0
            o_mux_sel <= (sel_field > `SAS_MAX_CH) ? 4'h0 : sel_field;
          end
        SAS_SAMPLE:
          if (tick)
          begin
            conv_cnt <= conv_cnt + 6'h1;
            if (conv_cnt == `SAS_SAMPLE_CLKS - 6'h1)
            begin
              state <= SAS_APPROX;
              bitpos <= 4'(`SAS_SAR_BITS - 1);
              o_dac_code <= `SAS_SAR_MSB;
            end
          end
        SAS_APPROX:
          if (tick)
          begin
            conv_cnt <= conv_cnt + 6'h1;
            o_dac_code[bitpos] <= i_cmp;
            if (bitpos != 4'h0)
            begin
              o_dac_code[bitpos - 4'h1] <= 1'b1;
              bitpos <= bitpos - 4'h1;
            end
            else
              state <= SAS_IDLE;
          end
        default: state <= SAS_IDLE;
      endcase
    end
  end

  // result and done flag; flag drops while a conversion runs
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      result <= 12'h0;
      done_flag <= 1'b0;
    end
    else if (finish)
    begin
      result <= {o_dac_code[11:1], i_cmp};
      done_flag <= 1'b1;
    end
    else if (accept)
      done_flag <= 1'b0;
  end

  // sticky events; read clears only what was returned, set wins
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      irq_stat <= 2'h0;
    else if (acc & i_avs_read & (i_avs_address == `SAS_OFS_STAT))
      irq_stat <= (irq_stat & ~o_avs_readdata[1:0]) | done_set | lost_set;
    else
      irq_stat <= irq_stat | done_set | lost_set;
  end

  // registered status outputs
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_irq <= 1'b0;
      o_busy <= 1'b0;
      o_sample <= 1'b0;
    end
    else
    begin
      o_irq <= |(irq_stat & irq_mask);
      o_busy <= accept | ((state != SAS_IDLE) & ~finish);
      o_sample <= accept | ((state == SAS_SAMPLE) &
        ~(tick & (conv_cnt == `SAS_SAMPLE_CLKS - 6'h1)));
    end
  end

  // checks
  a_bus_answer: assert property (@(posedge i_clk) disable iff (!i_nrst)
    req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("waitrequest did not drop after one cycle");
  a_sel_range: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_mux_sel <= `SAS_MAX_CH)
    else $error("routed input out of range");
  a_sel_match: assert property (@(posedge i_clk) disable iff (!i_nrst)
    accept && sel_field <= `SAS_MAX_CH |=> o_mux_sel == $past(sel_field))
    else $error("routed input differs from select field");
  a_done_busy: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state != SAS_IDLE) |-> !done_flag)
    else $error("done flag high during conversion");
  a_finish_done: assert property (@(posedge i_clk) disable iff (!i_nrst)
    finish |=> done_flag && irq_stat[`SAS_ST_DONE] && state == SAS_IDLE)
    else $error("finish did not set done and status");
  a_conv_len: assert property (@(posedge i_clk) disable iff (!i_nrst)
    finish |-> conv_cnt == `SAS_CONV_CLKS - 6'h1)
    else $error("conversion length not 58 converter clocks");
  a_start_clear: assert property (@(posedge i_clk) disable iff (!i_nrst)
    accept |=> !soft_start && state == SAS_SAMPLE)
    else $error("soft start not cleared on acceptance");
  a_busy_ignore: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state != SAS_IDLE) && any_trig && !finish |=>
    $stable(o_mux_sel) && state != SAS_IDLE)
    else $error("trigger disturbed running conversion");
  a_hw_start: assert property (@(posedge i_clk) disable iff (!i_nrst)
    state == SAS_IDLE && hw_trig |=> o_busy && o_sample)
    else $error("hardware trigger not accepted");
  a_sar_msb: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(state == SAS_APPROX) |-> o_dac_code == `SAS_SAR_MSB)
    else $error("approximation did not start at midscale");
  a_tick_div: assert property (@(posedge i_clk) disable iff (!i_nrst)
    tick && div == 5'h1 && $stable(div) && state != SAS_IDLE && !finish |->
    ##1 !tick ##1 tick)
    else $error("prescaler period wrong");
  c_soft_conv: cover property (@(posedge i_clk) disable iff (!i_nrst)
    accept && soft_start ##[1:600] finish);
  c_pwm_conv: cover property (@(posedge i_clk) disable iff (!i_nrst)
    accept && trig_sel == SAS_TRIG_PWM);
  c_lost: cover property (@(posedge i_clk) disable iff (!i_nrst)
    lost_set[`SAS_ST_LOST]);
  c_irq: cover property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(o_irq));
endmodule // sas_adc_seq
`default_nettype wire

/* File: testbench/sas_cmp_model.sv */
// Purpose: comparator array facing the converter's trial code
// Assumes: one analog level per input, set by the bench
// Notes: output is noise while sampling, as a real comparator may be
`timescale 1ns/1ps
`default_nettype none
module sas_cmp_model
(
  input wire logic i_clk,
  input wire logic [3:0] i_mux_sel,
  input wire logic i_sample,
  input wire logic [11:0] i_dac_code,
  input wire logic [11:0] i_level [0:10],
  output logic o_cmp
);
  logic tgl = 1'b0;
  logic [3:0] ch;
  // toggles so no lucky settle during sampling hides a bad tick
  always @(posedge i_clk)
    tgl <= ~tgl;
  // out-of-range select reads input 0
  assign ch = (i_mux_sel > 4'ha) ? 4'h0 : i_mux_sel;
  // one routed input against the trial code
  assign o_cmp = i_sample ? tgl : (i_level[ch] >= i_dac_code);
endmodule // sas_cmp_model
`default_nettype wire

/* File: testbench/tb_sar_adc_sequencer.sv */
// Purpose: self-checking bench for the converter sequencer
// Assumes: Avalon slave answers after a wait cycle, one clock domain
// Notes: reads queue their expected word, a monitor compares them
`timescale 1ns/1ps
`default_nettype none
`include "sas_map.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module tb_sar_adc_sequencer;
  import sas_pkg::*;
  logic i_clk = 0, i_nrst = 0, rd = 0, wr = 0, pwm = 0, cmp, smp, busy;
  logic irq, wq;
  logic [4:0] adr = 0;
  logic [31:0] wd = 0, rdata;
  logic [2:0] tm = 0;
  logic [3:0] sel;
  sas_code_t dac;
  sas_code_t lvl [0:10];
  logic [63:0] q [$];
  int miscompares = 0, n_tests = 0, bcnt = 0, dv = 0;
  sas_adc_seq DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wq), .i_timer_match(tm),
    .i_pwm_trig(pwm), .i_cmp(cmp), .o_mux_sel(sel), .o_sample(smp),
    .o_dac_code(dac), .o_busy(busy), .o_irq(irq));
  sas_cmp_model u_cmp (.i_clk(i_clk), .i_mux_sel(sel), .i_sample(smp),
    .i_dac_code(dac), .i_level(lvl), .o_cmp(cmp));
  // clock and busy-cycle tally
  always #4 i_clk = ~i_clk;
  always @(posedge i_clk)
    if (busy === 1'b1) bcnt <= bcnt + 1;
  // read data compared against the oldest note
  always @(posedge i_clk)
  begin
    if (rd && wq === 1'b0)
    begin
      `CHK(rdata & q[0][63:32], q[0][31:0])
      void'(q.pop_front());
    end
  end
  // one Avalon access, held until waitrequest is seen low
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge i_clk);
    while (wq !== 1'b0 && n < 50)
    begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 50) miscompares++;
    rd <= 0;
    wr <= 0;
  endtask
  task rdx(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    q.push_back({m, e});
    bus(0, a, 0);
  endtask
  // bounded wait for the busy level
  task waitb(input logic v);
    int n;
    n = 0;
    while (busy !== v && n < 4000)
    begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 4000) miscompares++;
  endtask
  // k 0 soft start, 1..3 timer a..c match, 4 pwm trigger
  task pulse(input int k);
    @(posedge i_clk);
    if (k > 3) pwm <= 1;
    else tm <= 3'(1 << (k - 1));
    @(posedge i_clk);
    pwm <= 0;
    tm <= 0;
  endtask
  task conv(input logic [3:0] s, input int k, input logic [31:0] m);
    logic [31:0] c;
    int b0;
    c = {28'h0, s} | (k > 3 ? 32'h20 : (k > 0 ? 32'h10 : 32'h0));
    bus(1, `SAS_OFS_MASK, m);
    b0 = bcnt;
    bus(1, `SAS_OFS_CTRL, c | (k == 0 ? 32'h100 : 32'h0));
    if (k > 0) pulse(k);
    waitb(1);
    rdx(`SAS_OFS_CTRL, 32'h1100, 0);
    waitb(0);
    `CHK(bcnt-b0 >= 58*(dv+1)-1 && bcnt-b0 <= 58*(dv+1)+1, 1'b1)
    repeat (2) @(posedge i_clk);
    `CHK(irq, m[0])
    rdx(`SAS_OFS_RESULT, '1, {20'h0, lvl[s > 10 ? 0 : s]});
    rdx(`SAS_OFS_CTRL, '1, c | 32'h1000);
    rdx(`SAS_OFS_STAT, '1, 1);
    repeat (2) @(posedge i_clk);
    `CHK(irq, 1'b0)
  endtask
  task close_out;
    $display("mismatches %0d, comparisons %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // hang guard, far beyond the longest expected run
  initial
  begin
    #(8 * 40000);
    miscompares++;
    close_out;
  end
  // main sequence
  initial
  begin
    void'($urandom(32'hd33a));
    foreach (lvl[i]) lvl[i] = sas_code_t'($urandom);
    repeat (6) @(posedge i_clk);
    i_nrst <= 1;
    bus(1, 5'h14, '1);
    for (int a = 0; a < 24; a += 4) rdx(a[4:0], '1, 0);
    for (int k = 0; k < 12; k++)
    begin
      dv = (k == 11) ? 31 : ((k == 1) ? 1 : $urandom_range(3));
      bus(1, `SAS_OFS_DIV, 32'hffffffe0 | dv);
      rdx(`SAS_OFS_DIV, '1, dv);
      conv((k == 11) ? 4'hf : k[3:0], 0, {31'h0, k[0]});
    end
    dv = 0;
    bus(1, `SAS_OFS_DIV, 0);
    for (int k = 1; k < 5; k++) conv(4'($urandom_range(10)), k, 1);
    bus(1, `SAS_OFS_CTRL, 32'h13);
    pulse(1);
    waitb(1);
    pulse(2);
    bus(1, `SAS_OFS_CTRL, 32'h113);
    waitb(0);
    rdx(`SAS_OFS_RESULT, '1, {20'h0, lvl[3]});
    rdx(`SAS_OFS_STAT, '1, 3);
    repeat (4) @(posedge i_clk);
    `CHK(busy, 1'b0)
    close_out;
  end
endmodule // tb_sar_adc_sequencer
`default_nettype wire
